// *** core/residual_differential_protection.sv ***
// Purpose: Residual differential stage with biased characteristic
// Assumes: AXI4-Lite slave, one sample strobe per 5 ms update
// Notes: Three-stage pipeline from sample strobe to operate flag
//
// Notes on behaviour
// - Differential is phase vector sum combined with the selected residual phasor.
// - Low-impedance differential with user-adjustable biased threshold.
// - Every update evaluates phase, residual, bias and differential quantities.
// - Only fundamental-frequency phasors of all inputs are used.
// - Calculated and measured residual are always both used.
// - Selector picks residual input one or two.
// - Cable-end mode operates only while measured residual is available; the difference is still calculated.
// - General settings are static, not part of any setting group.
// - Node behaviour: on, blocked, test, test-blocked, off; resets to on.
// - Forcing normal, trip or blocked; effective only with global forcing enabled.
// - Restricted-earth-fault mode or cable-end mode; default restricted-earth-fault.
// - Compensation command on energised line captures calculated residual as offset.
// - Threshold: pick-up, then slope one, then slope two above turn points.
// - Bias is average of residual magnitudes or maximum of all magnitudes.
// - Measured residual is added to or subtracted from phase sum.
`timescale 1ns/100ps
`include "rdp_cfg.svh"
module residual_differential_protection
    import rdp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sample_valid,
    input wire phasor_t phase_a_current,
    input wire phasor_t phase_b_current,
    input wire phasor_t phase_c_current,
    input wire phasor_t residual_input_one,
    input wire phasor_t residual_input_two,
    input wire logic stage_forcing_enable,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic trip,
    output logic blocked,
    output logic test_mode
);
    // ****************************************
    // Functions
    // ****************************************
    function automatic logic signed [13:0] sin_q12(input logic [7:0] a);
        logic [13:0] m;
        m = 14'({7'h00, a[6:0]} * (14'h0080 - {7'h00, a[6:0]}));
        return a[7] ? -$signed(m) : $signed(m);
    endfunction

    function automatic comp_t proj(input logic [23:0] mag, input logic [7:0] a);
        logic signed [38:0] pr;
        pr = $signed({1'b0, mag}) * sin_q12(a);
        return comp_t'($signed(pr[38:12]));
    endfunction

    function automatic logic [29:0] approx_mag(input comp_t x, input comp_t y);
        logic [29:0] ax;
        logic [29:0] ay;
        logic [29:0] lo;
        ax = x[29] ? 30'(-x) : 30'(x);
        ay = y[29] ? 30'(-y) : 30'(y);
        lo = (ax > ay) ? ay : ax;
        return ((ax > ay) ? ax : ay) + ((lo + (lo << 1)) >> 3);
    endfunction

    function automatic logic [29:0] max2(input logic [29:0] a, input logic [29:0] b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a, input logic wr);
        if (a == `A_CTRL || a == `A_CMD || a == `A_PICKUP || a == `A_TURN1)
            return 1'b1;
        else if (a == `A_SLOPE1 || a == `A_TURN2 || a == `A_SLOPE2)
            return 1'b1;
        else if (a == `A_STATUS || a == `A_DIFF || a == `A_BIAS || a == `A_THRESH)
            return !wr;
        else
            return 1'b0;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction

    // ****************************************
    // Settings held outside any setting group
    // ****************************************
    ctrl_t ctrl_q;
    logic [23:0] pickup_q, turn1_q, turn2_q;
    logic [15:0] slope1_q, slope2_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q, w_have_q, comp_pend_q, comp_valid_q;
    logic wr_fire;
    comp_t off_x_q, off_y_q;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q <= '0;
            pickup_q <= `RST_PICKUP;
            turn1_q <= `RST_TURN1;
            slope1_q <= `RST_SLOPE1;
            turn2_q <= `RST_TURN2;
            slope2_q <= `RST_SLOPE2;
        end
        else if (wr_fire)
        begin
            // Static settings, written only by software
            if (awaddr_q == `A_CTRL)
                ctrl_q <= ctrl_t'({23'h000000,
                    `CTRL_BITS'(merge(32'(ctrl_q), wdata_q, wstrb_q))});
            else if (awaddr_q == `A_PICKUP)
                pickup_q <= 24'(merge({8'h00, pickup_q}, wdata_q, wstrb_q));
            else if (awaddr_q == `A_TURN1)
                turn1_q <= 24'(merge({8'h00, turn1_q}, wdata_q, wstrb_q));
            else if (awaddr_q == `A_SLOPE1)
                slope1_q <= 16'(merge({16'h0000, slope1_q}, wdata_q, wstrb_q));
            else if (awaddr_q == `A_TURN2)
                turn2_q <= 24'(merge({8'h00, turn2_q}, wdata_q, wstrb_q));
            else if (awaddr_q == `A_SLOPE2)
                slope2_q <= 16'(merge({16'h0000, slope2_q}, wdata_q, wstrb_q));
        end
    end

    // ****************************************
    // Stage 1: rectangular sums
    // ****************************************
    phasor_t rsel;
    comp_t calc_x, calc_y, res_x, res_y, cx, cy, dx, dy;
    logic energised;
    comp_t s1_calc_x_q, s1_calc_y_q, s1_dx_q, s1_dy_q;
    logic [29:0] s1_phmax_q, s1_resmag_q;
    logic s1_valid_q, s1_avail_q;

    always_comb
    begin
        rsel = ctrl_q.res_two ? residual_input_two : residual_input_one;
        // Fundamental phasors only
        calc_x = proj(phase_a_current.mag, phase_a_current.ang + `QUARTER_TURN)
               + proj(phase_b_current.mag, phase_b_current.ang + `QUARTER_TURN)
               + proj(phase_c_current.mag, phase_c_current.ang + `QUARTER_TURN);
        calc_y = proj(phase_a_current.mag, phase_a_current.ang)
               + proj(phase_b_current.mag, phase_b_current.ang)
               + proj(phase_c_current.mag, phase_c_current.ang);
        res_x = proj(rsel.mag, rsel.ang + `QUARTER_TURN);
        res_y = proj(rsel.mag, rsel.ang);
        // Offset applies only in cable-end mode
        cx = ctrl_q.cable_end_diff_mode ? calc_x - off_x_q : calc_x;
        cy = ctrl_q.cable_end_diff_mode ? calc_y - off_y_q : calc_y;
        // Calculated and measured residual both used
        dx = ctrl_q.subtract ? cx - res_x : cx + res_x;
        dy = ctrl_q.subtract ? cy - res_y : cy + res_y;
        energised = (phase_a_current.mag > `ENERGISED_LEVEL)
                 || (phase_b_current.mag > `ENERGISED_LEVEL)
                 || (phase_c_current.mag > `ENERGISED_LEVEL);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1_valid_q <= 1'b0;
            s1_avail_q <= 1'b0;
            s1_calc_x_q <= '0;
            s1_calc_y_q <= '0;
            s1_dx_q <= '0;
            s1_dy_q <= '0;
            s1_phmax_q <= '0;
            s1_resmag_q <= '0;
        end
        else
        begin
            s1_valid_q <= sample_valid;
            if (sample_valid)
            begin
                s1_calc_x_q <= cx;
                s1_calc_y_q <= cy;
                s1_dx_q <= dx;
                s1_dy_q <= dy;
                s1_avail_q <= rsel.mag != 24'h000000;
                s1_phmax_q <= max2(max2({6'h00, phase_a_current.mag},
                    {6'h00, phase_b_current.mag}), {6'h00, phase_c_current.mag});
                s1_resmag_q <= {6'h00, rsel.mag};
            end
        end
    end

    // ****************************************
    // Compensation of natural unbalance
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            comp_pend_q <= 1'b0;
            comp_valid_q <= 1'b0;
            off_x_q <= '0;
            off_y_q <= '0;
        end
        else
        begin
            if (sample_valid)
                comp_pend_q <= 1'b0;
            if (sample_valid && comp_pend_q && energised)
            begin
                off_x_q <= calc_x;
                off_y_q <= calc_y;
                comp_valid_q <= 1'b1;
            end
            else if (wr_fire && awaddr_q == `A_CMD && wstrb_q[0] && wdata_q[`CMD_CLEAR])
            begin
                off_x_q <= '0;
                off_y_q <= '0;
                comp_valid_q <= 1'b0;
            end
            if (wr_fire && awaddr_q == `A_CMD && wstrb_q[0] && wdata_q[`CMD_COMP])
                comp_pend_q <= 1'b1;
        end
    end

    // ****************************************
    // Stage 2: magnitudes and bias
    // ****************************************
    logic [29:0] s2_diff_q, s2_bias_q, calc_mag;
    logic s2_valid_q, s2_avail_q;

    assign calc_mag = approx_mag(s1_calc_x_q, s1_calc_y_q);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s2_valid_q <= 1'b0;
            s2_avail_q <= 1'b0;
            s2_diff_q <= '0;
            s2_bias_q <= '0;
        end
        else
        begin
            s2_valid_q <= s1_valid_q;
            if (s1_valid_q)
            begin
                s2_avail_q <= s1_avail_q;
                s2_diff_q <= approx_mag(s1_dx_q, s1_dy_q);
                if (ctrl_q.bias_max)
                    s2_bias_q <= max2(s1_phmax_q, s1_resmag_q);
                else
                    s2_bias_q <= 30'((31'(calc_mag) + 31'(s1_resmag_q)) >> 1);
            end
        end
    end

    // ****************************************
    // Stage 3: biased threshold and operate
    // ****************************************
    logic [47:0] thr;
    logic [29:0] thr_q;
    logic operate_q;

    always_comb
    begin
        // Piecewise characteristic
        if (s2_bias_q < {6'h00, turn1_q})
            thr = {24'h000000, pickup_q};
        else if (s2_bias_q <= {6'h00, turn2_q})
            thr = {24'h000000, pickup_q}
                + (48'(slope1_q) * 48'(s2_bias_q - {6'h00, turn1_q})) / `SLOPE_SCALE;
        else
            thr = {24'h000000, pickup_q}
                + (48'(slope1_q) * 48'(turn2_q - turn1_q)) / `SLOPE_SCALE
                + (48'(slope2_q) * 48'(s2_bias_q - {6'h00, turn2_q})) / `SLOPE_SCALE;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            thr_q <= '0;
            operate_q <= 1'b0;
        end
        else if (s2_valid_q)
        begin
            thr_q <= 30'(thr);
            // Suppressed in cable-end mode without residual
            operate_q <= (48'(s2_diff_q) > thr)
                && (!ctrl_q.cable_end_diff_mode || s2_avail_q);
        end
    end

    // ****************************************
    // Node behaviour and forcing
    // ****************************************
    logic force_act, force_trip, force_block;
    assign force_act = stage_forcing_enable && ctrl_q.force_sel != FORCE_NORMAL;
    assign force_trip = force_act && ctrl_q.force_sel == FORCE_TRIP;
    assign force_block = force_act && ctrl_q.force_sel == FORCE_BLOCKED;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            trip <= 1'b0;
            blocked <= 1'b0;
            test_mode <= 1'b0;
        end
        else
        begin
            test_mode <= ctrl_q.node_behaviour_select == NB_TEST
                      || ctrl_q.node_behaviour_select == NB_TEST_BLOCKED;
            if (force_act)
            begin
                trip <= force_trip;
                blocked <= force_block;
            end
            else
            begin
                case (ctrl_q.node_behaviour_select)
                    NB_ON, NB_TEST:
                    begin
                        trip <= operate_q;
                        blocked <= 1'b0;
                    end
                    NB_BLOCKED, NB_TEST_BLOCKED:
                    begin
                        trip <= 1'b0;
                        blocked <= 1'b1;
                    end
                    default:
                    begin
                        trip <= 1'b0;
                        blocked <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(awaddr_q, 1'b1) ? `RESP_OKAY : `RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr, 1'b0) ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_araddr == `A_CTRL)
                s_axi_rdata <= 32'(ctrl_q);
            else if (s_axi_araddr == `A_PICKUP)
                s_axi_rdata <= {8'h00, pickup_q};
            else if (s_axi_araddr == `A_TURN1)
                s_axi_rdata <= {8'h00, turn1_q};
            else if (s_axi_araddr == `A_SLOPE1)
                s_axi_rdata <= {16'h0000, slope1_q};
            else if (s_axi_araddr == `A_TURN2)
                s_axi_rdata <= {8'h00, turn2_q};
            else if (s_axi_araddr == `A_SLOPE2)
                s_axi_rdata <= {16'h0000, slope2_q};
            else if (s_axi_araddr == `A_STATUS)
                s_axi_rdata <= {26'h0000000, comp_valid_q, comp_pend_q, operate_q,
                                test_mode, blocked, trip};
            else if (s_axi_araddr == `A_DIFF)
                s_axi_rdata <= {2'h0, s2_diff_q};
            else if (s_axi_araddr == `A_BIAS)
                s_axi_rdata <= {2'h0, s2_bias_q};
            else if (s_axi_araddr == `A_THRESH)
                s_axi_rdata <= {2'h0, thr_q};
            else
                s_axi_rdata <= '0;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_pipe;
        s1_valid_q ##1 s2_valid_q;
    endsequence

    AST_PIPE: assert property (sample_valid |=> s_pipe)
        else $error("Sample did not pass through pipeline");
    AST_FORCE_TRIP: assert property (force_trip |=> trip && !blocked)
        else $error("Forced trip not driven");
    AST_FORCE_BLOCK: assert property (force_block |=> blocked && !trip)
        else $error("Forced block not driven");
    AST_OFF: assert property (!force_act && ctrl_q.node_behaviour_select == NB_OFF
        |=> !trip && !blocked)
        else $error("Off node still active");
    AST_TRIP_ON: assert property (!force_act && ctrl_q.node_behaviour_select == NB_ON
        |=> trip == $past(operate_q))
        else $error("Trip does not follow operate");
    AST_CED_SUPPRESS: assert property (s2_valid_q && ctrl_q.cable_end_diff_mode
        && !s2_avail_q |=> !operate_q)
        else $error("Cable-end operate without residual");
    AST_FLAT: assert property (s2_valid_q && s2_bias_q < {6'h00, turn1_q}
        |=> thr_q == {6'h00, pickup_q})
        else $error("Threshold below turn point one not pick-up");
    AST_COMP: assert property (sample_valid && comp_pend_q && energised
        |=> off_x_q == $past(calc_x) && comp_valid_q ##1 !comp_pend_q)
        else $error("Compensation offset not captured");
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped");
endmodule

// *** include/rdp_cfg.svh ***
// Purpose: Offsets, field positions, reset values and scaling constants
// Assumes: Currents in units of 0.0001 In, slopes in units of 0.01 %
// Notes: Definitions only
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define A_CTRL 8'h00
`define A_CMD 8'h04
`define A_PICKUP 8'h08
`define A_TURN1 8'h0C
`define A_SLOPE1 8'h10
`define A_TURN2 8'h14
`define A_SLOPE2 8'h18
`define A_STATUS 8'h1C
`define A_DIFF 8'h20
`define A_BIAS 8'h24
`define A_THRESH 8'h28
// ****************************************
// Field positions
// ****************************************
`define CMD_COMP 0
`define CMD_CLEAR 1
`define CTRL_BITS 9
// ****************************************
// Reset values
// ****************************************
`define RST_PICKUP 24'h0003E8
`define RST_TURN1 24'h002710
`define RST_SLOPE1 16'h03E8
`define RST_TURN2 24'h007530
`define RST_SLOPE2 16'h0FA0
// ****************************************
// Scaling and levels
// ****************************************
`define SLOPE_SCALE 48'h000000002710
`define ENERGISED_LEVEL 24'h0001F4
`define QUARTER_TURN 8'h40
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** include/rdp_pkg.sv ***
// Purpose: Types shared by the residual differential block
// Assumes: Angles are 8 bits per full turn
// Notes: Constants live in rdp_cfg.svh
package rdp_pkg;
    typedef struct packed {
        logic [23:0] mag;
        logic [7:0] ang;
    } phasor_t;
    typedef logic signed [29:0] comp_t;
    typedef enum logic [2:0] {
        NB_ON = 3'h0,
        NB_BLOCKED = 3'h1,
        NB_TEST = 3'h2,
        NB_TEST_BLOCKED = 3'h3,
        NB_OFF = 3'h4
    } node_behaviour_t;
    typedef enum logic [1:0] {
        FORCE_NORMAL = 2'h0,
        FORCE_TRIP = 2'h1,
        FORCE_BLOCKED = 2'h2
    } force_t;
    typedef struct packed {
        logic [22:0] rsvd;
        logic bias_max;
        logic subtract;
        logic res_two;
        logic cable_end_diff_mode;
        force_t force_sel;
        logic [2:0] node_behaviour_select;
    } ctrl_t;
endpackage

// *** sim/front_end_model.sv ***
// Purpose: Measurement front end model
// Assumes: 5 ms time base scaled to PERIOD cycles
// Notes: Phases b and c and residual two idle at zero
`timescale 1ns/100ps
module front_end_model
    import rdp_pkg::*;
#(
    parameter int PERIOD = 40
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire phasor_t set_a,
    input wire phasor_t set_one,
    output logic sample_valid,
    output phasor_t phase_a_current,
    output phasor_t phase_b_current,
    output phasor_t phase_c_current,
    output phasor_t residual_input_one,
    output phasor_t residual_input_two
);
    // ****************************************
    // Update strobe and phasor set
    // ****************************************
    int cnt_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 0;
            sample_valid <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
            sample_valid <= (cnt_q == PERIOD - 1);
        end
    end
    // Magnitude and angle of all five inputs
    assign phase_a_current = set_a;
    assign phase_b_current = '0;
    assign phase_c_current = '0;
    assign residual_input_one = set_one;
    assign residual_input_two = '0;
endmodule

// *** sim/residual_differential_protection_tb.sv ***
// Purpose: Self-checking bench for the residual differential stage
// Assumes: Front end model updates every 40 cycles
// Notes: Expectations from default characteristic settings
`timescale 1ns/100ps
`include "rdp_cfg.svh"
module residual_differential_protection_tb
    import rdp_pkg::*;
;
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic sys_clk, rst, sample_valid, stage_forcing_enable, trip, blocked, test_mode;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    phasor_t phase_a_current, phase_b_current, phase_c_current;
    phasor_t residual_input_one, residual_input_two, set_a, set_one;
    int fail_count, samples_checked;
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    residual_differential_protection i_residual_differential_protection (.sys_clk, .rst,
        .sample_valid, .phase_a_current, .phase_b_current, .phase_c_current,
        .residual_input_one, .residual_input_two, .stage_forcing_enable, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .trip, .blocked, .test_mode);
    front_end_model i_front_end_model (.sys_clk, .rst, .set_a, .set_one, .sample_valid,
        .phase_a_current, .phase_b_current, .phase_c_current, .residual_input_one,
        .residual_input_two);
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic hang();
        fail_count++;
        summarize();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (n = 0; n < 40; n++)
        begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 40) hang();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        int n;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40; n++)
        begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 40) hang();
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        chk(d, e);
        @(posedge sys_clk);
    endtask
    task automatic settle(input logic [31:0] ctrl, input logic [23:0] a, input logic [23:0] b);
        wr(`A_CTRL, ctrl);
        set_a <= {a, 8'h00};
        set_one <= {b, 8'h00};
        repeat (100) @(posedge sys_clk);
    endtask
    task automatic pins(input logic [2:0] e);
        chk({29'h0, trip, blocked, test_mode}, {29'h0, e});
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_defaults();
        rdchk(`A_CTRL, 32'h0);
        rdchk(`A_PICKUP, 32'h3E8);
        rdchk(`A_TURN1, 32'h2710);
        rdchk(`A_SLOPE1, 32'h3E8);
        rdchk(`A_TURN2, 32'h7530);
        rdchk(`A_SLOPE2, 32'hFA0);
        rdchk(8'h3C, 32'h0);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
        wr(`A_STATUS, 32'hF);
        chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    endtask
    task automatic t_trip();
        settle(32'h0, 24'h0, 24'h7D0);
        pins(3'h4);
        rdchk(`A_DIFF, 32'h7D0);
        rdchk(`A_BIAS, 32'h3E8);
        settle(32'h0, 24'h0, 24'h3E8);
        pins(3'h0);
        settle(32'h40, 24'h0, 24'h7D0);
        pins(3'h0);
    endtask
    task automatic t_bias();
        settle(32'h0, 24'h2EE0, 24'hFA0);
        rdchk(`A_THRESH, 32'h3E8);
        settle(32'h100, 24'h2EE0, 24'hFA0);
        rdchk(`A_THRESH, 32'h4B0);
        settle(32'h180, 24'h2EE0, 24'hFA0);
        rdchk(`A_DIFF, 32'h1F40);
        settle(32'h100, 24'h9C40, 24'h0);
        rdchk(`A_THRESH, 32'h1B58);
    endtask
    task automatic t_node();
        logic [2:0] i;
        for (i = 3'h0; i < 3'h5; i++)
        begin
            settle({29'h0, i}, 24'h0, 24'h7D0);
            pins({i == 3'h0 || i == 3'h2, i == 3'h1 || i == 3'h3, i[1]});
        end
    endtask
    task automatic t_force();
        settle(32'h8, 24'h0, 24'h0);
        pins(3'h0);
        stage_forcing_enable <= 1'b1;
        settle(32'h8, 24'h0, 24'h0);
        pins(3'h4);
        settle(32'h10, 24'h0, 24'h7D0);
        pins(3'h2);
        stage_forcing_enable <= 1'b0;
    endtask
    task automatic t_cable();
        settle(32'h20, 24'h7D0, 24'h0);
        pins(3'h0);
        settle(32'h20, 24'h7D0, 24'h64);
        pins(3'h4);
        wr(`A_CMD, 32'h1);
        settle(32'h20, 24'h7D0, 24'h64);
        rdchk(`A_DIFF, 32'h64);
        settle(32'h0, 24'h7D0, 24'h64);
        pins(3'h4);
        rdchk(`A_STATUS, 32'h29);
        wr(`A_CMD, 32'h2);
        rdchk(`A_STATUS, 32'h9);
    endtask
    initial
    begin
        {fail_count, samples_checked} = '0;
        {rst, s_axi_wstrb} = 5'h1F;
        {stage_forcing_enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {set_a, set_one} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_defaults();
        t_trip();
        t_bias();
        t_node();
        t_force();
        t_cable();
        summarize();
    end
endmodule
